/* common/rif_defs.vh */
/*
 * Constants for the radio interrupt logic: register offsets, field positions,
 * reset values and the status bit layout.
 * Assumes it is included by bare name by every design file that needs it.
 */
`ifndef RIF_DEFS_VH
`define RIF_DEFS_VH

// Register offsets on the register port.
`define RIF_ADDR_CTRL 6'h04
`define RIF_ADDR_MASK 6'h0e
`define RIF_ADDR_STATUS 6'h0f

// Reset values.
`define RIF_CTRL_RESET 8'h22
`define RIF_MASK_RESET 8'h00
`define RIF_STATUS_RESET 8'h00
`define RIF_READ_UNMAPPED 8'h00

// Control register fields.
`define RIF_CTRL_POLARITY 0
`define RIF_CTRL_MASK_MODE 1

// Status bit positions.
`define RIF_BIT_PLL_LOCK 0
`define RIF_BIT_PLL_UNLOCK 1
`define RIF_BIT_RX_START 2
`define RIF_BIT_FRAME_DONE 3
`define RIF_BIT_WAKE_MEAS 4
`define RIF_BIT_ADDR_MATCH 5
`define RIF_BIT_BUF_VIOL 6
`define RIF_BIT_SUPPLY_LOW 7

`endif

/* src/rif_flags.v */
/*
 * Sticky status flags of the radio interrupt logic.
 * Assumes same-clock event pulses and a one-cycle clearing read strobe.
 */
`timescale 1ns/1ps
`include "rif_defs.vh"

module rif_flags #(
    parameter WIDTH = 8
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Clearing from deep sleep or power-on.
    input wire power_clr,
    // Events already qualified for recording.
    input wire [WIDTH-1:0] record,
    // Raw lock pair events for cross clearing.
    input wire lock_ev,
    input wire unlock_ev,
    // Status register read strobe.
    input wire status_rd,
    // Flag state.
    output reg [WIDTH-1:0] flags_r
);

    reg [WIDTH-1:0] keep;
    reg [WIDTH-1:0] flags_nxt;

    // Work out which flags survive this cycle and merge in new events.
    always @*
    begin
        keep = status_rd ? {WIDTH{1'b0}} : flags_r;
        if (lock_ev)
        begin
            keep[`RIF_BIT_PLL_UNLOCK] = 1'b0;
        end
        if (unlock_ev)
        begin
            keep[`RIF_BIT_PLL_LOCK] = 1'b0;
        end
        flags_nxt = keep | record;
    end

    // Flags are cleared by reset and by the power-down paths.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            flags_r <= `RIF_STATUS_RESET;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

endmodule // rif_flags

/* src/rif_top.v */
/*
 * Interrupt aggregation of the radio transceiver: enable mask, control bits,
 * sticky status register, request pin and power amplifier cut-off.
 * Assumes event inputs are one-cycle pulses from logic on clk, and a simple
 * register port strobed for one cycle per access by the serial interface.
 * Assumes the event sources, the buffer-empty indicator and the transmit
 * state all come from logic on clk, so none of them is synchronised here.
 * Assumes the host reads the status register whenever the pin asserts and
 * when it enables a new event, since stale flags would otherwise fire at once.
 */
`timescale 1ns/1ps
`include "rif_defs.vh"

module rif_top #(
    parameter WIDTH = 8,
    parameter AW = 6
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Power-on and deep sleep clearing, a level from the power controller.
    input wire power_clr,

    // Register port.
    input wire [AW-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [WIDTH-1:0] reg_wdata,
    output reg [WIDTH-1:0] reg_rdata_r,
    output reg reg_rvalid_r,

    // Event pulses.
    input wire pll_lock_ev,
    input wire pll_unlock_ev,
    input wire rx_start_ev,
    input wire frame_done,
    input wire wake_complete,
    input wire channel_measure_done,
    input wire address_match_event,
    input wire buffer_access_violation,
    input wire supply_low_event,

    // Transceiver state.
    input wire tx_busy,
    input wire pa_request,
    output reg pa_enable_r,

    // Buffer-empty indicator.
    input wire buf_empty_ind_en,
    input wire buf_empty,

    // Interrupt request pin.
    output reg irq_pin_r,

    // Configuration views.
    output reg mask_mode_r,
    output reg polarity_r
);

    // Control, mask and helper state.
    reg [WIDTH-1:0] transceiver_control_one_r;
    reg [WIDTH-1:0] interrupt_enable_mask_r;
    reg pa_cut_r;
    reg [WIDTH-1:0] raw_events;
    reg [WIDTH-1:0] record;
    reg [WIDTH-1:0] rdata_nxt;
    reg irq_nxt;
    reg pa_cut_nxt;
    reg ctrl_hit_wr;
    reg mask_hit_wr;
    reg status_hit_rd;
    wire [WIDTH-1:0] interrupt_status;
    wire pending;

    // Reset levels of the two mode bits, picked out of the control reset value.
    localparam [WIDTH-1:0] CTRL_RESET = `RIF_CTRL_RESET;
    localparam [0:0] MASK_MODE_RESET = CTRL_RESET[`RIF_CTRL_MASK_MODE];
    localparam [0:0] POLARITY_RESET = CTRL_RESET[`RIF_CTRL_POLARITY];

    // Compare an address against a register offset.
    function hit;
        input [AW-1:0] addr;
        input [AW-1:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // Pick the read data for an offset; unmapped offsets read zero.
    function [WIDTH-1:0] read_mux;
        input [AW-1:0] addr;
        input [WIDTH-1:0] ctrl;
        input [WIDTH-1:0] mask;
        input [WIDTH-1:0] status;
        begin
            if (hit(addr, `RIF_ADDR_CTRL))
            begin
                read_mux = ctrl;
            end
            else if (hit(addr, `RIF_ADDR_MASK))
            begin
                read_mux = mask;
            end
            else if (hit(addr, `RIF_ADDR_STATUS))
            begin
                read_mux = status;
            end
            else
            begin
                read_mux = `RIF_READ_UNMAPPED;
            end
        end
    endfunction

    // Pin level: the buffer indicator is always active high, interrupts follow polarity.
    function pin_level;
        input ind_en;
        input empty;
        input req;
        input active_low;
        begin
            if (ind_en)
            begin
                pin_level = empty;
            end
            else if (active_low)
            begin
                pin_level = ~req;
            end
            else
            begin
                pin_level = req;
            end
        end
    endfunction

    // Decode the access strobes.
    // Writes to the status offset decode to nothing, so the host cannot set flags.
    always @*
    begin
        ctrl_hit_wr = reg_wr && hit(reg_addr, `RIF_ADDR_CTRL);
        mask_hit_wr = reg_wr && hit(reg_addr, `RIF_ADDR_MASK);
        status_hit_rd = reg_rd && hit(reg_addr, `RIF_ADDR_STATUS);
    end

    // Gather the nine event kinds onto the eight status positions.
    // The host cannot tell the two bit 4 causes apart; it knows what it started.
    always @*
    begin
        raw_events = {WIDTH{1'b0}};
        raw_events[`RIF_BIT_SUPPLY_LOW] = supply_low_event;
        raw_events[`RIF_BIT_BUF_VIOL] = buffer_access_violation;
        raw_events[`RIF_BIT_ADDR_MATCH] = address_match_event;
        // Wake completion and measurement end share one flag.
        raw_events[`RIF_BIT_WAKE_MEAS] = wake_complete | channel_measure_done;
        raw_events[`RIF_BIT_FRAME_DONE] = frame_done;
        raw_events[`RIF_BIT_RX_START] = rx_start_ev;
        raw_events[`RIF_BIT_PLL_UNLOCK] = pll_unlock_ev;
        raw_events[`RIF_BIT_PLL_LOCK] = pll_lock_ev;
    end

    // Record enabled events always, masked ones only in polling mode.
    // Without polling mode a masked event is lost for good, which is intended:
    // the host then only ever sees causes that it asked to be told about.
    always @*
    begin
        if (mask_mode_r)
        begin
            record = raw_events;
        end
        else
        begin
            record = raw_events & interrupt_enable_mask_r;
        end
    end

    // Sticky flags live in their own module.
    // The lock pair cross clearing uses the raw events, recorded or not.
    rif_flags #(
        .WIDTH(WIDTH)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .power_clr(power_clr),
        .record(record),
        .lock_ev(pll_lock_ev),
        .unlock_ev(pll_unlock_ev),
        .status_rd(status_hit_rd),
        .flags_r(interrupt_status)
    );

    // Only enabled pending flags request service; masked flags stay silent.
    // Enabling a bit whose flag is already set asserts the pin on the next cycle.
    assign pending = |(interrupt_status & interrupt_enable_mask_r);

    // Work out the pin level from pending state, polarity and indicator use.
    // The pin is registered after this, so it trails the flags by one cycle.
    always @*
    begin
        irq_nxt = pin_level(buf_empty_ind_en, buf_empty, pending, polarity_r);
    end

    // Hold the amplifier off after an unlock during transmission.
    // The cut is released only when transmission ends, so a relock in mid-frame
    // cannot switch the amplifier back on with a synthesizer of doubtful state.
    always @*
    begin
        pa_cut_nxt = pa_cut_r;
        if (pll_unlock_ev && tx_busy)
        begin
            pa_cut_nxt = 1'b1;
        end
        else if (!tx_busy)
        begin
            pa_cut_nxt = 1'b0;
        end
    end

    // Read data is captured in the cycle of the read strobe.
    // A status read returns the flags as they were before the clearing edge.
    always @*
    begin
        rdata_nxt = read_mux(reg_addr, transceiver_control_one_r,
            interrupt_enable_mask_r, interrupt_status);
    end

    // Control register: writable, reset by all clearing paths.
    // Only the two low bits act here; the others are kept for read back.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            transceiver_control_one_r <= `RIF_CTRL_RESET;
        end
        else if (ctrl_hit_wr)
        begin
            transceiver_control_one_r <= reg_wdata;
        end
    end

    // Enable mask: any value may be written, cleared on every reset path.
    // After any clearing path every event is masked, the wake event included.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            interrupt_enable_mask_r <= `RIF_MASK_RESET;
        end
        else if (mask_hit_wr)
        begin
            interrupt_enable_mask_r <= reg_wdata;
        end
    end

    // Polling mode mirror; it decides whether masked events are recorded.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            mask_mode_r <= MASK_MODE_RESET;
        end
        else if (ctrl_hit_wr)
        begin
            mask_mode_r <= reg_wdata[`RIF_CTRL_MASK_MODE];
        end
    end

    // Polarity mirror; it resets to zero so the pin starts active high.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            polarity_r <= POLARITY_RESET;
        end
        else if (ctrl_hit_wr)
        begin
            polarity_r <= reg_wdata[`RIF_CTRL_POLARITY];
        end
    end

    // Read answer strobe, one cycle after the read strobe.
    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_rvalid_r <= 1'b0;
        end
        else
        begin
            reg_rvalid_r <= reg_rd;
        end
    end

    // Read data, held until the next read so a slow host can still pick it up.
    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata_r <= `RIF_READ_UNMAPPED;
        end
        else if (reg_rd)
        begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // Request pin follows the flags one cycle later; idle level low at reset.
    // Reset drives it low whatever the polarity, which is zero after reset anyway.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            irq_pin_r <= 1'b0;
        end
        else
        begin
            irq_pin_r <= irq_nxt;
        end
    end

    // Cut latch: set by an unlock while transmitting, held until transmission ends.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            pa_cut_r <= 1'b0;
        end
        else
        begin
            pa_cut_r <= pa_cut_nxt;
        end
    end

    // Amplifier gate; it uses the next cut value so the cut takes effect at once.
    always @(posedge clk)
    begin
        if (rst || power_clr)
        begin
            pa_enable_r <= 1'b0;
        end
        else
        begin
            pa_enable_r <= pa_request && !pa_cut_nxt;
        end
    end

endmodule // rif_top

/* verif/rif_top_asserts.sv */
/* Checker of the radio interrupt logic, bound to rif_top.
   Assumes only the top module's ports and a single clock domain. */
`timescale 1ns/1ps
module rif_top_asserts #(
    parameter WIDTH = 8,
    parameter AW = 6
) (
    // Clock and resets.
    input logic clk,
    input logic rst,
    input logic power_clr,
    // Register port.
    input logic [AW-1:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [WIDTH-1:0] reg_wdata,
    input logic [WIDTH-1:0] reg_rdata_r,
    input logic reg_rvalid_r,
    // State, indicator and pin.
    input logic pll_unlock_ev,
    input logic tx_busy,
    input logic pa_request,
    input logic pa_enable_r,
    input logic buf_empty_ind_en,
    input logic buf_empty,
    input logic irq_pin_r,
    input logic mask_mode_r,
    input logic polarity_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A control write lands in the mirrors; a missed enable shows here.
    wire ctrl_wr = reg_wr && reg_addr == 6'h04 && !power_clr;

    // Every read strobe gets exactly one answer pulse.
    a_read_answer: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read not answered");
    a_no_answer: assert property (!reg_rd |=> !reg_rvalid_r)
        else $error("answer without read");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {6'h04, 6'h0e, 6'h0f})
        |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_write: assert property (ctrl_wr |=> polarity_r == $past(reg_wdata[0])
        && mask_mode_r == $past(reg_wdata[1]))
        else $error("control write lost");
    a_ctrl_hold: assert property (!ctrl_wr && !power_clr |=> $stable(polarity_r))
        else $error("polarity changed alone");
    a_pa_cut: assert property (pll_unlock_ev && tx_busy |=> !pa_enable_r)
        else $error("amplifier not cut on unlock");
    a_pa_follow: assert property ((!tx_busy && !power_clr) [*2]
        |-> pa_enable_r == $past(pa_request))
        else $error("amplifier enable wrong");
    a_buf_indicator: assert property (buf_empty_ind_en && !power_clr
        |=> irq_pin_r == $past(buf_empty))
        else $error("pin not showing buffer empty");
    a_power_clear: assert property (power_clr |=> !irq_pin_r && !pa_enable_r
        && mask_mode_r && !polarity_r)
        else $error("power clear incomplete");

    // Main scenarios reached.
    c_status_read: cover property (reg_rd && reg_addr == 6'h0f);
    c_pa_cut: cover property (pll_unlock_ev && tx_busy);
    c_buf_ind: cover property (buf_empty_ind_en && buf_empty);
endmodule // rif_top_asserts

bind rif_top rif_top_asserts #(.WIDTH(WIDTH), .AW(AW)) rif_top_asserts_i (
    .clk, .rst, .power_clr, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_r, .reg_rvalid_r, .pll_unlock_ev, .tx_busy, .pa_request,
    .pa_enable_r, .buf_empty_ind_en, .buf_empty, .irq_pin_r, .mask_mode_r,
    .polarity_r
);

/* verif/rif_host_model.sv */
/* Host model: owns the register port and serves the request pin.
   Assumes the device clock; it drives at falling edges. */
`timescale 1ns/1ps
module rif_host_model (
    // Clock.
    input logic clk,
    // Register port.
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata_r,
    input logic reg_rvalid_r,
    // Request pin.
    input logic irq_pin_r,
    input logic polarity_r
);
    // Idle bus at time zero.
    initial
    begin
        reg_addr = 6'h3f;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h5a;
    end

    // One write; released lines are scrambled so stale values never help.
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask

    // One read; data counts only with the answer pulse.
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid_r ? reg_rdata_r : 8'hxx;
    endtask

    // Handler: read the status only while the pin is active.
    task automatic service(output logic [7:0] d);
        d = 8'hxx;
        if (irq_pin_r !== polarity_r)
            rd(6'h0f, d);
    endtask
endmodule // rif_host_model

/* verif/radio_interrupt_logic_test.sv */
/* Testbench of the radio interrupt logic.
   Assumes rif_top, its checker and the host model are compiled first. */
`timescale 1ns/1ps
module radio_interrupt_logic_test;
    logic clk = 0, rst = 1, power_clr = 0;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_r, d;
    logic reg_wr, reg_rd, reg_rvalid_r, pa_enable_r, irq_pin_r, mask_mode_r, polarity_r;
    logic [8:0] ev = 0;
    logic tx_busy = 0, pa_request = 0, buf_en = 0, buf_empty = 0;
    int fails = 0;
    int tests_run = 0;

    // Clock of 5 ns.
    always #2.5 clk = ~clk;

    rif_top rif_top_i (
        .clk, .rst, .power_clr, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata_r, .reg_rvalid_r, .pll_lock_ev(ev[0]), .pll_unlock_ev(ev[1]),
        .rx_start_ev(ev[2]), .frame_done(ev[3]), .wake_complete(ev[4]),
        .channel_measure_done(ev[5]), .address_match_event(ev[6]),
        .buffer_access_violation(ev[7]), .supply_low_event(ev[8]), .tx_busy,
        .pa_request, .pa_enable_r, .buf_empty_ind_en(buf_en), .buf_empty,
        .irq_pin_r, .mask_mode_r, .polarity_r
    );
    rif_host_model rif_host_model_i (
        .clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r,
        .reg_rvalid_r, .irq_pin_r, .polarity_r
    );

    task check(string n, logic [7:0] s, logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task rchk(string n, logic [5:0] a, logic [7:0] e);
        rif_host_model_i.rd(a, d);
        check(n, d, e);
    endtask

    task cyc(int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle event pulse; event 5 shares status bit 4 with event 4.
    task pulse(int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev[i] = 1'b0;
    endtask

    function logic [7:0] bit_of(int i);
        bit_of = 8'h01 << (i < 5 ? i : i - 1);
    endfunction

    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog far beyond the expected few hundred cycles.
    initial
    begin
        #10000;
        fails++;
        end_of_test;
    end

    // Main sequence.
    initial
    begin
        cyc(3);
        rst = 0;
        rchk("mask", 6'h0e, 8'h00);
        rchk("ctrl", 6'h04, 8'h22);
        rchk("status", 6'h0f, 8'h00);
        rchk("unmapped", 6'h3a, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 9; i++)
        begin
            pulse(i);
            cyc(4);
            check("irq", irq_pin_r, 8'h00);
            rchk("status", 6'h0f, bit_of(i));
        end
        rchk("cleared", 6'h0f, 8'h00);
        $display("test polling done");
        rif_host_model_i.wr(6'h04, 8'h00);
        for (int i = 0; i < 9; i++)
            pulse(i);
        rchk("status", 6'h0f, 8'h00);
        rif_host_model_i.wr(6'h0e, 8'h08);
        rchk("history", 6'h0f, 8'h00);
        pulse(3);
        cyc(1);
        check("irq", irq_pin_r, 8'h01);
        rif_host_model_i.service(d);
        check("serviced", d, 8'h08);
        cyc(2);
        check("irq", irq_pin_r, 8'h00);
        pulse(8);
        cyc(2);
        check("irq", irq_pin_r, 8'h00);
        rchk("status", 6'h0f, 8'h00);
        $display("test mask done");
        rif_host_model_i.wr(6'h04, 8'h03);
        cyc(2);
        check("irq", irq_pin_r, 8'h01);
        check("mode", {mask_mode_r, polarity_r}, 8'h03);
        pulse(3);
        cyc(1);
        check("irq", irq_pin_r, 8'h00);
        rchk("status", 6'h0f, 8'h08);
        cyc(2);
        check("irq", irq_pin_r, 8'h01);
        buf_en = 1;
        cyc(2);
        check("irq", irq_pin_r, 8'h00);
        buf_empty = 1;
        cyc(2);
        check("irq", irq_pin_r, 8'h01);
        buf_en = 0;
        buf_empty = 0;
        rif_host_model_i.wr(6'h04, 8'h02);
        $display("test polarity done");
        pulse(0);
        pulse(1);
        rchk("unlock", 6'h0f, 8'h02);
        pulse(1);
        pulse(0);
        rchk("lock", 6'h0f, 8'h01);
        fork
            rif_host_model_i.rd(6'h0f, d);
            pulse(3);
        join
        check("race", d, 8'h00);
        rchk("kept", 6'h0f, 8'h08);
        pulse(4);
        rif_host_model_i.wr(6'h0e, 8'h18);
        rchk("history", 6'h0f, 8'h10);
        cyc(1);
        check("irq", irq_pin_r, 8'h00);
        pulse(4);
        cyc(1);
        check("irq", irq_pin_r, 8'h01);
        rif_host_model_i.service(d);
        check("wake", d, 8'h10);
        $display("test clearing done");
        pa_request = 1;
        cyc(2);
        check("pa", pa_enable_r, 8'h01);
        tx_busy = 1;
        pulse(1);
        check("pa", pa_enable_r, 8'h00);
        cyc(3);
        check("pa", pa_enable_r, 8'h00);
        tx_busy = 0;
        cyc(2);
        check("pa", pa_enable_r, 8'h01);
        rif_host_model_i.wr(6'h0e, 8'hff);
        power_clr = 1;
        cyc(1);
        power_clr = 0;
        rchk("mask", 6'h0e, 8'h00);
        rchk("ctrl", 6'h04, 8'h22);
        rchk("status", 6'h0f, 8'h00);
        $display("test power done");
        end_of_test;
    end
endmodule // radio_interrupt_logic_test
